/* File: dv/au_host_if_sva.sv */
// Assertion checker for the arithmetic unit host port
`timescale 1ns/1ps
module au_host_if_sva
#(
   parameter int EXEC_CYCLES = 17
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Host bus
   input wire logic cs_n_in,
   input wire logic cmd_data_select_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe_out,
   // Handshake and completion
   input wire logic ready_out,
   input wire logic end_n_out,
   input wire logic service_req_out,
   input wire logic done_ack_n_in,
   input wire logic service_ack_n_in
);
   // ==========================================================
   // Helper logic
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   int low_cnt;
   // Length of the current ready-low run; a stall may span one execution
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         low_cnt <= 0;
      else
         low_cnt <= ready_out ? 0 : low_cnt + 1;
   end
   // ==========================================================
   // Properties
   a_ready_bounded:
      assert property (low_cnt <= EXEC_CYCLES + 12)
      else $error("ready held low too long");
   a_ready_cause:
      assert property ($fell(ready_out) |->
         $past(!cs_n_in && !(rd_n_in && wr_n_in), 3))
      else $error("ready fell without an access");
   a_read_drive:
      assert property ($rose(data_oe_out) |->
         $fell(ready_out) && $past(!rd_n_in, 3))
      else $error("data bus driven without a read");
   a_data_holds:
      assert property ($changed(data_out) |->
         data_oe_out && !$past(ready_out))
      else $error("output latch changed outside a read");
   a_svc_with_end:
      assert property ($rose(service_req_out) |-> $fell(end_n_out))
      else $error("service request apart from end");
   a_end_ack:
      assert property (!done_ack_n_in [*6] |=> end_n_out)
      else $error("end not cleared by acknowledge");
   a_svc_ack:
      assert property (!service_ack_n_in [*6] |=> !service_req_out)
      else $error("service request not cleared");
   a_end_stands:
      assert property ($rose(end_n_out) |-> $past(!done_ack_n_in, 2))
      else $error("end cleared without acknowledge");
   a_svc_stands:
      assert property ($fell(service_req_out) |->
         $past(!service_ack_n_in, 2))
      else $error("service request dropped unasked");
endmodule

/* File: dv/au_host_model.sv */
// Behavioural host processor driving the arithmetic unit bus
`timescale 1ns/1ps
module au_host_model
(
   // Clock
   input wire logic clk_in,
   // Handshake and read data from the unit
   input wire logic ready_in,
   input wire logic [7:0] data_in,
   // Bus controls and write data
   output logic cs_n_out,
   output logic cmd_data_select_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic [7:0] data_out,
   // Completion acknowledges
   output logic done_ack_n_out,
   output logic service_ack_n_out
);
   int timeouts = 0;
   int wait_cyc = 0;
   // Idle bus at time zero
   initial
   begin
      cs_n_out = 1'b1;
      cmd_data_select_out = 1'b0;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      data_out = 8'hA5;
      done_ack_n_out = 1'b1;
      service_ack_n_out = 1'b1;
   end
   // ==========================================================
   // Bus cycle
   // select and strobe pick the access
   task automatic bus(input logic cmd, input logic wr,
      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      wait_cyc = 0;
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      cmd_data_select_out <= cmd;
      rd_n_out <= wr;
      wr_n_out <= ~wr;
      if (wr)
         data_out <= wd;
      // controls stay put until ready returns high
      while (ready_in && n < 20)
      begin
         @(posedge clk_in);
         n++;
      end
      while (!ready_in && wait_cyc < 400)
      begin
         @(posedge clk_in);
         wait_cyc++;
      end
      if (n >= 20 || wait_cyc >= 400)
         timeouts++;
      rd = data_in;
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      data_out <= ~data_out; // Released bus shows no stale byte
      // Release must pass the pin filter before the next access
      repeat (6) @(posedge clk_in);
   endtask
   // acknowledge pulse, long enough to pass the pin filter
   task automatic ack(input logic svc);
      @(posedge clk_in);
      if (svc)
         service_ack_n_out <= 1'b0;
      else
         done_ack_n_out <= 1'b0;
      repeat (8) @(posedge clk_in);
      service_ack_n_out <= 1'b1;
      done_ack_n_out <= 1'b1;
      repeat (2) @(posedge clk_in);
   endtask
endmodule

/* File: dv/test_arith_unit_host_interface.sv */
// Self-checking bench for the arithmetic unit host port
`timescale 1ns/1ps
module test_arith_unit_host_interface;
   import au_pkg::*;
   // ==========================================================
   // Clock, reset and wiring
   localparam int EXEC = 40;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cs_n, cds, rd_n, wr_n, oe, ready, end_n, svc, dack_n, sack_n;
   logic [7:0] wdata, qdata, rdata;
   int errors = 0;
   int tests_run = 0;
   // Free running 25 MHz clock
   always #20 clk_in = ~clk_in;
   au_host_if #(.EXEC_CYCLES(EXEC)) uut (.clk_in(clk_in),
      .rstn_in(rstn_in), .cs_n_in(cs_n), .cmd_data_select_in(cds),
      .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(wdata),
      .data_out(qdata), .data_oe_out(oe), .ready_out(ready),
      .end_n_out(end_n), .service_req_out(svc),
      .done_ack_n_in(dack_n), .service_ack_n_in(sack_n));
   au_host_model host (.clk_in(clk_in), .ready_in(ready),
      .data_in(qdata), .cs_n_out(cs_n), .cmd_data_select_out(cds),
      .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(wdata),
      .done_ack_n_out(dack_n), .service_ack_n_out(sack_n));
   // ==========================================================
   // Shared tasks
   task automatic chk(input string name, input logic [7:0] exp,
      input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude;
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One access; a hung handshake ends the run
   task automatic acc(input logic cmd, input logic wr,
      input logic [7:0] wd);
      host.bus(cmd, wr, wd, rdata);
      if (host.timeouts != 0)
      begin
         errors++;
         conclude();
      end
   endtask
   task automatic wait_end;
      int n;
      n = 0;
      while (end_n !== 1'b0 && n < 200)
      begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 200)
      begin
         errors++;
         conclude();
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      chk("ready", 8'h01, {7'h00, ready});
      chk("end", 8'h01, {7'h00, end_n});
      chk("svc", 8'h00, {7'h00, svc});
      chk("oe", 8'h00, {7'h00, oe});
      acc(1'b1, 1'b0, 8'h00);
      chk("status", 8'h20, rdata);
      chk("wait", 8'h01, host.wait_cyc[7:0]);
   endtask
   // Seventeen pushes overflow the bottom; pops come back newest first
   task automatic t_stack;
      for (int i = 0; i < 17; i++)
      begin
         acc(1'b0, 1'b1, 8'h10 + i[7:0]);
         chk("wait", 8'h01, host.wait_cyc[7:0]);
      end
      for (int i = 0; i < 17; i++)
      begin
         acc(1'b0, 1'b0, 8'h00);
         chk("pop", 8'h20 - {4'h0, i[3:0]}, rdata);
         chk("wait", 8'h01, host.wait_cyc[7:0]);
      end
   endtask
   // Arithmetic table: status flags and byte order of results
   task automatic t_ops;
      logic [7:0] cmd [6] = '{8'h81, 8'h02, 8'h01, 8'h03, 8'h04, 8'h85};
      logic [31:0] nx [6] = '{32'h7FFF, 32'h0, 32'hFFFF, 32'hFFFF,
         32'h8000_0000, 32'h1234};
      logic [31:0] rs [6] = '{32'h8000, 32'hFFFF, 32'h0, 32'h10000,
         32'h7FFF_FFFF, 32'hFFFF_1234};
      logic [7:0] st [6] = '{8'h42, 8'h41, 8'h21, 8'h00, 8'h02, 8'h40};
      int nb;
      int np;
      for (int c = 0; c < 6; c++)
      begin
         // Negate pops four bytes: the operand below must survive
         nb = (c == 3 || c == 4) ? 4 : 2;
         np = (c >= 3) ? 4 : 2;
         for (int b = 0; b < nb; b++)
            acc(1'b0, 1'b1, nx[c][8*b +: 8]);
         for (int b = 0; b < nb; b++)
            acc(1'b0, 1'b1, (b == 0) ? 8'h01 : 8'h00);
         acc(1'b1, 1'b1, cmd[c]);
         acc(1'b1, 1'b0, 8'h00);
         chk("busy", 8'h80, rdata & 8'h80);
         chk("wait", 8'h01, host.wait_cyc[7:0]);
         wait_end();
         chk("svc", {7'h00, cmd[c][7]}, {7'h00, svc});
         acc(1'b1, 1'b0, 8'h00);
         chk("status", st[c], rdata);
         for (int b = np - 1; b >= 0; b--)
         begin
            acc(1'b0, 1'b0, 8'h00);
            chk("result", rs[c][8*b +: 8], rdata);
         end
         host.ack(1'b0);
         host.ack(1'b1);
         chk("end", 8'h01, {7'h00, end_n});
         chk("svc", 8'h00, {7'h00, svc});
      end
   endtask
   // Accesses made while busy must wait out the execution
   task automatic t_stall;
      acc(1'b0, 1'b1, 8'h05);
      acc(1'b0, 1'b1, 8'h00);
      acc(1'b0, 1'b1, 8'h03);
      acc(1'b0, 1'b1, 8'h00);
      acc(1'b1, 1'b1, 8'h02);
      acc(1'b0, 1'b0, 8'h00);
      chk("stall", 8'h01, {7'h00, host.wait_cyc > 20});
      chk("result", 8'h00, rdata);
      acc(1'b1, 1'b1, 8'h00);
      acc(1'b1, 1'b1, 8'h00);
      chk("stall", 8'h01, {7'h00, host.wait_cyc > 20});
      acc(1'b0, 1'b0, 8'h00);
      chk("result", 8'h02, rdata);
      host.ack(1'b0);
   endtask
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      t_reset();
      t_stack();
      t_ops();
      t_stall();
      conclude();
   end
endmodule
bind au_host_if au_host_if_sva #(.EXEC_CYCLES(EXEC_CYCLES)) u_sva (
   .clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
   .cmd_data_select_in(cmd_data_select_in), .rd_n_in(rd_n_in),
   .wr_n_in(wr_n_in), .data_in(data_in), .data_out(data_out),
   .data_oe_out(data_oe_out), .ready_out(ready_out),
   .end_n_out(end_n_out), .service_req_out(service_req_out),
   .done_ack_n_in(done_ack_n_in), .service_ack_n_in(service_ack_n_in));

/* File: verilog/au_host_if.sv */
// Host port, operand stack and status of the arithmetic unit
`timescale 1ns/1ps
// How it works
// - Sixteen byte stack, eight 16-bit entries
// - Same bytes viewed as four 32-bit values
// - Byte transfers, read out in reverse order
// - Data write pushes byte, bottom byte lost
// - Data read returns top, top rotates down
// - Command write starts execution, host continues
// - Two-operand uses top and next; single top
// - Completion drops end, clears busy, service request if command asked
// - Acknowledge pulses clear end and service request
// - Command during busy stalls until execution ends
// - Stack access during busy stalls until done
// - Idle read stalls only for latch transfer
// - Idle write ready once latch is free
// - Status read stalls for latch, always allowed
// - Command-side read returns status any time
// - Status: busy, sign, zero, fault, carry
// - Sign and zero follow stack top value
// - Fault field uses the listed outcome codes
// - Carry set on carry or borrow out
// - Other status bits undefined while busy
// - Fixed point is two's complement, sign MSB
module au_host_if
   import au_pkg::*;
#(
   parameter int EXEC_CYCLES = AU_EXEC_CYCLES
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Host bus controls
   input wire logic cs_n_in,
   input wire logic cmd_data_select_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   // Host data bus
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_out,
   // Wait handshake
   output logic ready_out,
   // Completion signalling
   output logic end_n_out,
   output logic service_req_out,
   input wire logic done_ack_n_in,
   input wire logic service_ack_n_in
);
   // ==========================================================
   // Pin synchronisation
   typedef enum logic [1:0] {AU_IDLE, AU_STALL, AU_XFER, AU_HOLD} au_st_e;

   logic [AU_SYNC_W-1:0] pins_raw;
   logic [AU_SYNC_W-1:0] pins;
   logic cs_n;
   logic cds;
   logic rd_n;
   logic wr_n;
   logic ack_done_n;
   logic ack_svc_n;
   logic [7:0] din;

   assign pins_raw = {cs_n_in, cmd_data_select_in, rd_n_in, wr_n_in,
                      data_in};
   assign {cs_n, cds, rd_n, wr_n, din} = pins[AU_SYNC_W-1:0];

   au_sync #(.W(AU_SYNC_W), .INIT(12'hF00)) u_bus_sync
   (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in(pins_raw),
      .q_out(pins)
   );

   au_sync #(.W(2), .INIT(2'h3)) u_ack_sync
   (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in({done_ack_n_in, service_ack_n_in}),
      .q_out({ack_done_n, ack_svc_n})
   );

   // ==========================================================
   // Access decode
   logic acc_rd;
   logic acc_wr;
   logic acc_any;
   logic is_push;
   logic is_pop;
   logic is_cmd;
   logic is_stat;

   assign acc_rd = ~cs_n & ~rd_n;
   assign acc_wr = ~cs_n & ~wr_n & rd_n;
   assign acc_any = acc_rd | acc_wr;
   assign is_push = acc_wr & ~cds;
   assign is_pop = acc_rd & ~cds;
   assign is_cmd = acc_wr & cds;
   assign is_stat = acc_rd & cds;

   // ==========================================================
   // Operand stack and status state
   logic [7:0] stk [0:AU_STACK_BYTES-1];
   logic busy;
   logic [7:0] cmd;
   logic fmt32;
   logic carry;
   logic [3:0] err;
   logic [$clog2(EXEC_CYCLES+1)-1:0] cnt;
   au_st_e state;
   au_st_e next_state;

   // ==========================================================
   // Operand views and arithmetic
   logic [15:0] top16;
   logic [15:0] nxt16;
   logic [31:0] top32;
   logic [31:0] nxt32;
   logic [3:0] op;
   logic [16:0] r16;
   logic [32:0] r32;
   logic ovf16;
   logic ovf32;
   logic sub_op;
   logic sign_now;
   logic zero_now;
   logic [7:0] status;
   logic done;

   // top two bytes form the 16-bit top entry
   // first written byte sits deeper, so it leaves last
   assign top16 = {stk[0], stk[1]};
   assign nxt16 = {stk[2], stk[3]};
   // four bytes form one 32-bit value
   assign top32 = {stk[0], stk[1], stk[2], stk[3]};
   assign nxt32 = {stk[4], stk[5], stk[6], stk[7]};
   assign op = cmd[AU_CMD_OP_HI:0];
   assign sub_op = (op == AU_OP_SUB16) | (op == AU_OP_SUB32);

   // two operands: next minus or plus top
   // two's complement arithmetic, sign in the MSB
   assign r16 = sub_op ? ({1'b0, nxt16} - {1'b0, top16})
                       : ({1'b0, nxt16} + {1'b0, top16});
   assign r32 = sub_op ? ({1'b0, nxt32} - {1'b0, top32})
                       : ({1'b0, nxt32} + {1'b0, top32});
   // Signed overflow: operands' signs versus result sign
   assign ovf16 = sub_op
      ? (nxt16[15] ^ top16[15]) & (r16[15] ^ nxt16[15])
      : ~(nxt16[15] ^ top16[15]) & (r16[15] ^ nxt16[15]);
   assign ovf32 = sub_op
      ? (nxt32[31] ^ top32[31]) & (r32[31] ^ nxt32[31])
      : ~(nxt32[31] ^ top32[31]) & (r32[31] ^ nxt32[31]);

   // sign and zero track the live stack top
   assign sign_now = stk[0][7];
   assign zero_now = fmt32 ? (top32 == 32'h0000_0000)
                           : (top16 == 16'h0000);
   // fields are only meaningful once busy is clear
   assign status = {busy, sign_now, zero_now, err, carry};
   assign done = busy & (cnt == ($bits(cnt))'(EXEC_CYCLES - 1));

   // ==========================================================
   // Bus handshake sequencer
   always_comb
   begin
      next_state = state;
      unique case (state)
         AU_IDLE:
         begin
            // busy stalls commands and stack access
            // status reads never wait for busy
            if (acc_any)
               next_state = (busy & ~is_stat) ? AU_STALL : AU_XFER;
         end
         AU_STALL:
         begin
            // controls held by host, so decode stays valid
            if (!busy)
               next_state = AU_XFER;
         end
         AU_XFER:
            next_state = AU_HOLD;
         AU_HOLD:
         begin
            if (!acc_any)
               next_state = AU_IDLE;
         end
      endcase
   end

   // ready low while stalled and for the one transfer cycle
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state <= AU_IDLE;
         ready_out <= 1'b1;
         data_oe_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ready_out <= (next_state == AU_IDLE) | (next_state == AU_HOLD);
         data_oe_out <= acc_rd;
      end
   end

   // ==========================================================
   // Output latch
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         data_out <= AU_BYTE_RST;
      else if (state == AU_XFER && is_stat)
         data_out <= status;
      // top byte moves into the latch
      else if (state == AU_XFER && is_pop)
         data_out <= stk[0];
   end

   // ==========================================================
   // Operand stack storage
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         for (int i = 0; i < AU_STACK_BYTES; i++)
            stk[i] <= AU_BYTE_RST;
      end
      else if (done)
      begin
         // Undefined slots take the next operand's bytes, not zero
         if (op == AU_OP_ADD16 || op == AU_OP_SUB16)
         begin
            stk[0] <= r16[15:8];
            stk[1] <= r16[7:0];
            for (int i = 2; i < AU_STACK_BYTES - 2; i++)
               stk[i] <= stk[i+2];
            stk[AU_STACK_BYTES-2] <= stk[2];
            stk[AU_STACK_BYTES-1] <= stk[3];
         end
         else if (op == AU_OP_ADD32 || op == AU_OP_SUB32)
         begin
            {stk[0], stk[1], stk[2], stk[3]} <= r32[31:0];
            for (int i = 4; i < AU_STACK_BYTES - 4; i++)
               stk[i] <= stk[i+4];
            for (int i = 0; i < 4; i++)
               stk[AU_STACK_BYTES-4+i] <= stk[4+i];
         end
         // single-operand command touches only the top
         else if (op == AU_OP_CHS16)
            {stk[0], stk[1]} <= 16'h0000 - top16;
      end
      else if (state == AU_XFER && is_push)
      begin
         // push down, bottom byte falls off
         stk[0] <= din;
         for (int i = 1; i < AU_STACK_BYTES; i++)
            stk[i] <= stk[i-1];
      end
      else if (state == AU_XFER && is_pop)
      begin
         // removed byte rotates to the bottom
         for (int i = 0; i < AU_STACK_BYTES - 1; i++)
            stk[i] <= stk[i+1];
         stk[AU_STACK_BYTES-1] <= stk[0];
      end
   end

   // ==========================================================
   // Command execution and result flags
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         busy <= 1'b0;
         cmd <= AU_CMD_RST;
         cnt <= '0;
         fmt32 <= 1'b0;
         carry <= 1'b0;
         err <= AU_ERR_NONE;
      end
      else if (state == AU_XFER && is_cmd)
      begin
         busy <= 1'b1;
         cmd <= din;
         cnt <= '0;
      end
      else if (done)
      begin
         busy <= 1'b0;
         fmt32 <= (op == AU_OP_ADD32) | (op == AU_OP_SUB32);
         unique case (op)
            AU_OP_ADD16, AU_OP_SUB16:
            begin
               // carry or borrow out of the MSB
               carry <= r16[16];
               err <= ovf16 ? AU_ERR_OVER : AU_ERR_NONE;
            end
            AU_OP_ADD32, AU_OP_SUB32:
            begin
               // carry or borrow out of the MSB
               carry <= r32[32];
               err <= ovf32 ? AU_ERR_OVER : AU_ERR_NONE;
            end
            AU_OP_CHS16:
            begin
               carry <= 1'b0;
               // negating the most negative value overflows
               err <= (top16 == 16'h8000) ? AU_ERR_OVER : AU_ERR_NONE;
            end
            default:
            begin
               // Unknown opcodes behave as a no-operation
               carry <= 1'b0;
               err <= AU_ERR_NONE;
            end
         endcase
      end
      else if (busy)
         cnt <= cnt + 1'b1;
   end

   // ==========================================================
   // Completion outputs
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         end_n_out <= 1'b1;
         service_req_out <= 1'b0;
      end
      else
      begin
         // end low on completion; set beats acknowledge
         if (done)
            end_n_out <= 1'b0;
         else if (!ack_done_n)
            end_n_out <= 1'b1;
         // service request only if command asked for it
         if (done && cmd[AU_CMD_SVC])
            service_req_out <= 1'b1;
         else if (!ack_svc_n)
            service_req_out <= 1'b0;
      end
   end
endmodule

/* File: verilog/au_pkg.sv */
// Shared constants for the arithmetic unit host interface
package au_pkg;
   // ==========================================================
   // Stack geometry
   localparam int AU_STACK_BYTES = 16;
   localparam int AU_BYTE_W = 8;
   // ==========================================================
   // Status register field positions
   localparam int AU_ST_BUSY = 7;
   localparam int AU_ST_SIGN = 6;
   localparam int AU_ST_ZERO = 5;
   localparam int AU_ST_ERR_HI = 4;
   localparam int AU_ST_ERR_LO = 1;
   localparam int AU_ST_CARRY = 0;
   // ==========================================================
   // Result fault codes
   localparam logic [3:0] AU_ERR_NONE = 4'h0;
   localparam logic [3:0] AU_ERR_DIV0 = 4'h8;
   localparam logic [3:0] AU_ERR_NEG = 4'h4;
   localparam logic [3:0] AU_ERR_BIG = 4'hC;
   localparam logic [3:0] AU_ERR_UNDER = 4'h2;
   localparam logic [3:0] AU_ERR_OVER = 4'h1;
   // ==========================================================
   // Command byte layout and opcodes
   localparam int AU_CMD_SVC = 7;
   localparam int AU_CMD_OP_HI = 3;
   localparam logic [3:0] AU_OP_NOP = 4'h0;
   localparam logic [3:0] AU_OP_ADD16 = 4'h1;
   localparam logic [3:0] AU_OP_SUB16 = 4'h2;
   localparam logic [3:0] AU_OP_ADD32 = 4'h3;
   localparam logic [3:0] AU_OP_SUB32 = 4'h4;
   localparam logic [3:0] AU_OP_CHS16 = 4'h5;
   // ==========================================================
   // Reset values, cycle count and synchroniser width
   localparam logic [7:0] AU_BYTE_RST = 8'h00;
   localparam logic [7:0] AU_CMD_RST = 8'h00;
   localparam int AU_EXEC_CYCLES = 17;
   localparam int AU_SYNC_W = 12;
endpackage

/* File: verilog/au_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module au_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Raw pins and filtered result
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] agree;

   // Only bits on which stage two and three agree may change
   assign agree = ~(s2 ^ s3);

   // Stage one feeds stage two alone, never any logic
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q_out <= INIT;
      end
      else
      begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
         q_out <= (agree & s3) | (~agree & q_out);
      end
   end
endmodule
